// File: hw/pbu_blend_device.sv
`timescale 1ns/1ns
module pbu_blend_device (
  input wire logic mclk,
  input wire logic nrst,
  pbu_pixel_bus_if.device bus,
  input wire logic [pbu_pkg::BUS_W-1:0] pbuf_rd_data,
  input wire logic [pbu_pkg::UNITS*pbu_pkg::FRAC_W-1:0] const_value,
  input wire logic pass_out,
  input wire logic [1:0] pass_in,
  input pbu_pkg::pbu_frac_sel_t frac_sel_color,
  input pbu_pkg::pbu_frac_sel_t frac_sel_alpha,
  input pbu_pkg::pbu_data_sel_t data_sel_color,
  input pbu_pkg::pbu_data_sel_t data_sel_alpha,
  input pbu_pkg::pbu_add_sel_t add_sel_color,
  input pbu_pkg::pbu_add_sel_t add_sel_alpha,
  input pbu_pkg::pbu_data_sel_t pre_data_sel_color,
  input pbu_pkg::pbu_data_sel_t pre_data_sel_alpha,
  input pbu_pkg::pbu_loop_sel_t loop_sel_color,
  input pbu_pkg::pbu_loop_sel_t loop_sel_alpha,
  output logic [pbu_pkg::BUS_W-1:0] pbuf_wr_data,
  output logic [pbu_pkg::UNITS-1:0] pbuf_wr_be,
  output logic preblend_armed
);
  typedef enum logic {
    PBU_PH_NORMAL, PBU_PH_ARMED
  } pbu_phase_t;

  typedef struct packed {
    pbu_phase_t phase;
    logic [pbu_pkg::UNITS-1:0][pbu_pkg::LANE_W-1:0] loop_mpy;
    logic [pbu_pkg::UNITS-1:0][pbu_pkg::LANE_W-1:0] loop_add;
    logic [pbu_pkg::BUS_W-1:0] wr_data;
    logic [pbu_pkg::UNITS-1:0] wr_be;
  } pbu_dev_state_t;

  pbu_dev_state_t st_ff;
  pbu_dev_state_t nxt_st;

  logic [pbu_pkg::LANE_W-1:0] src_alpha;
  logic [pbu_pkg::LANE_W-1:0] dst_alpha;
  logic [pbu_pkg::LANE_W-1:0] asat;
  logic is_init;
  logic is_write;
  logic two_cycle;
  logic pass_ok;
  logic [pbu_pkg::UNITS-1:0][pbu_pkg::LANE_W-1:0] unit_prod;
  logic [pbu_pkg::UNITS-1:0][pbu_pkg::LANE_W-1:0] unit_clamped;

  // source alpha rides the top byte of the bus, destination alpha the top buffer byte
  assign src_alpha = bus.pixel_data_bus[pbu_pkg::ALPHA_LSB +: pbu_pkg::LANE_W];
  assign dst_alpha = pbuf_rd_data[pbu_pkg::ALPHA_LSB +: pbu_pkg::LANE_W];
  // one-minus by inversion: off by one count from true 1-x, but costs no adder
  assign asat = (src_alpha < ~dst_alpha) ? src_alpha : ~dst_alpha;

  assign is_init = bus.pixel_write_enable && (bus.pixel_op_code == pbu_pkg::OP_INIT_TWO_CYCLE);
  assign is_write = bus.pixel_write_enable && (bus.pixel_op_code != pbu_pkg::OP_INIT_TWO_CYCLE);
  assign two_cycle = (st_ff.phase == PBU_PH_ARMED);
  assign pass_ok = pass_out && (pass_in == pbu_pkg::PASS_IN_ALL);

  for (genvar u = 0; u < pbu_pkg::UNITS; u++) begin : g_unit
    logic [pbu_pkg::LANE_W-1:0] lane;
    logic lane_x;
    logic [pbu_pkg::LANE_W-1:0] pbyte;
    logic [pbu_pkg::FRAC_W-1:0] kval;
    pbu_pkg::pbu_frac_sel_t fsel;
    pbu_pkg::pbu_data_sel_t dsel;
    pbu_pkg::pbu_add_sel_t asel;
    pbu_pkg::pbu_loop_sel_t lsel;
    logic [pbu_pkg::FRAC_W-1:0] frac_raw;
    logic [pbu_pkg::FRAC_W-1:0] frac;
    logic [pbu_pkg::LANE_W-1:0] data;
    logic [pbu_pkg::SUM_W-1:0] addend;
    logic [pbu_pkg::PROD_W-1:0] prod_full;
    logic [pbu_pkg::SUM_W-1:0] sum;

    assign lane = bus.pixel_data_bus[u*pbu_pkg::LANE_W +: pbu_pkg::LANE_W];
    assign lane_x = bus.pixel_extension_bits[u];
    assign pbyte = pbuf_rd_data[u*pbu_pkg::LANE_W +: pbu_pkg::LANE_W];
    assign kval = const_value[u*pbu_pkg::FRAC_W +: pbu_pkg::FRAC_W];

    // the alpha unit has its own selections, so alpha-saturate can use f on colour, 1 on alpha
    always_comb begin
      if (u == pbu_pkg::ALPHA_UNIT) begin
        fsel = frac_sel_alpha;
        dsel = is_init ? pre_data_sel_alpha : data_sel_alpha;
        asel = add_sel_alpha;
        lsel = loop_sel_alpha;
      end else begin
        fsel = frac_sel_color;
        dsel = is_init ? pre_data_sel_color : data_sel_color;
        asel = add_sel_color;
        lsel = loop_sel_color;
      end
    end

    always_comb begin
      if (is_init) begin
        frac_raw = {lane_x, lane};
      end else begin
        unique case (fsel)
          pbu_pkg::PBU_FR_BUS: frac_raw = {lane_x, lane};
          pbu_pkg::PBU_FR_ALPHA_BUS: frac_raw = {bus.pixel_extension_bits[pbu_pkg::ALPHA_UNIT],
                                                 src_alpha};
          pbu_pkg::PBU_FR_PBUF: frac_raw = {1'b0, pbyte};
          pbu_pkg::PBU_FR_CONST: frac_raw = kval;
          pbu_pkg::PBU_FR_ONE: frac_raw = pbu_pkg::FRAC_ONE;
          default: frac_raw = pbu_pkg::FRAC_ONE;
        endcase
      end
    end

    assign frac = (frac_raw > pbu_pkg::FRAC_ONE) ? pbu_pkg::FRAC_ONE : frac_raw;

    always_comb begin
      unique case (dsel)
        pbu_pkg::PBU_DT_PBUF: data = pbyte;
        pbu_pkg::PBU_DT_PBUF_INV: data = ~pbyte;
        pbu_pkg::PBU_DT_ASAT: data = asat;
        pbu_pkg::PBU_DT_SRC_ALPHA: data = src_alpha;
        pbu_pkg::PBU_DT_DST_ALPHA: data = dst_alpha;
        pbu_pkg::PBU_DT_DST_ALPHA_INV: data = ~dst_alpha;
        default: data = pbyte;
      endcase
    end

    // 1.00h times 255 gives FF00h, so the kept byte never overflows
    assign prod_full = {{(pbu_pkg::PROD_W-pbu_pkg::FRAC_W){1'b0}}, frac} *
                       {{(pbu_pkg::PROD_W-pbu_pkg::LANE_W){1'b0}}, data};
    assign unit_prod[u] = prod_full[pbu_pkg::PROD_MSB:pbu_pkg::PROD_LSB];

    always_comb begin
      if (is_init) begin
        addend = {lane_x, lane_x, lane};
      end else if (two_cycle) begin
        unique case (lsel)
          pbu_pkg::PBU_LB_ADD: addend = {2'b00, st_ff.loop_add[u]};
          pbu_pkg::PBU_LB_MPY: addend = {2'b00, st_ff.loop_mpy[u]};
        endcase
      end else begin
        unique case (asel)
          pbu_pkg::PBU_AD_BUS: addend = {lane_x, lane_x, lane};
          pbu_pkg::PBU_AD_CONST: addend = {kval[pbu_pkg::FRAC_W-1], kval};
          pbu_pkg::PBU_AD_PBUF: addend = {2'b00, pbyte};
          default: addend = {2'b00, pbyte};
        endcase
      end
    end

    assign sum = {2'b00, unit_prod[u]} + addend;

    always_comb begin
      if (sum[pbu_pkg::SUM_W-1]) begin
        unit_clamped[u] = pbu_pkg::SAT_MIN;
      end else if (sum[pbu_pkg::SUM_W-2]) begin
        unit_clamped[u] = pbu_pkg::SAT_MAX;
      end else begin
        unit_clamped[u] = sum[pbu_pkg::LANE_W-1:0];
      end
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.wr_be = '0;
    if (is_init) begin
      // preblend writes nothing; it only parks product and lane addend
      nxt_st.phase = PBU_PH_ARMED;
      for (int i = 0; i < pbu_pkg::UNITS; i++) begin
        nxt_st.loop_mpy[i] = unit_prod[i];
        nxt_st.loop_add[i] = bus.pixel_data_bus[i*pbu_pkg::LANE_W +: pbu_pkg::LANE_W];
      end
    end else if (is_write) begin
      nxt_st.phase = PBU_PH_NORMAL;
      nxt_st.wr_data = unit_clamped;
      if (pass_ok) begin
        nxt_st.wr_be = bus.pixel_byte_enable;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pbuf_wr_data = st_ff.wr_data;
  assign pbuf_wr_be = st_ff.wr_be;
  assign preblend_armed = (st_ff.phase == PBU_PH_ARMED);
endmodule // pbu_blend_device

// File: hw/pbu_pixel_bus_if.sv
`timescale 1ns/1ns
interface pbu_pixel_bus_if;
  logic [pbu_pkg::BUS_W-1:0] pixel_data_bus;
  logic [pbu_pkg::UNITS-1:0] pixel_extension_bits;
  logic [pbu_pkg::OP_W-1:0] pixel_op_code;
  logic pixel_write_enable;
  logic [pbu_pkg::UNITS-1:0] pixel_byte_enable;

  modport host (
    output pixel_data_bus,
    output pixel_extension_bits,
    output pixel_op_code,
    output pixel_write_enable,
    output pixel_byte_enable
  );

  modport device (
    input pixel_data_bus,
    input pixel_extension_bits,
    input pixel_op_code,
    input pixel_write_enable,
    input pixel_byte_enable
  );
endinterface

// File: hw/pbu_pkg.sv
package pbu_pkg;
  localparam int UNITS = 4;
  localparam int LANE_W = 8;
  localparam int FRAC_W = 9;
  localparam int SUM_W = 10;
  localparam int PROD_W = 17;
  localparam int BUS_W = 32;
  localparam int OP_W = 3;
  localparam int ALPHA_UNIT = 3;
  localparam int ALPHA_LSB = 24;
  localparam int PROD_LSB = 8;
  localparam int PROD_MSB = 15;
  localparam logic [OP_W-1:0] OP_INIT_TWO_CYCLE = 3'h6;
  localparam logic [OP_W-1:0] OP_STATEFUL_WRITE = 3'h0;
  localparam logic [FRAC_W-1:0] FRAC_ONE = 9'h100;
  localparam logic [LANE_W-1:0] SAT_MAX = 8'hFF;
  localparam logic [LANE_W-1:0] SAT_MIN = 8'h00;
  localparam logic [1:0] PASS_IN_ALL = 2'h3;

  typedef enum logic [2:0] {
    PBU_FR_BUS, PBU_FR_ALPHA_BUS, PBU_FR_PBUF, PBU_FR_CONST, PBU_FR_ONE
  } pbu_frac_sel_t;

  typedef enum logic [2:0] {
    PBU_DT_PBUF, PBU_DT_PBUF_INV, PBU_DT_ASAT, PBU_DT_SRC_ALPHA,
    PBU_DT_DST_ALPHA, PBU_DT_DST_ALPHA_INV
  } pbu_data_sel_t;

  typedef enum logic [1:0] {
    PBU_AD_BUS, PBU_AD_CONST, PBU_AD_PBUF
  } pbu_add_sel_t;

  typedef enum logic {
    PBU_LB_ADD, PBU_LB_MPY
  } pbu_loop_sel_t;
endpackage

// File: hw/pbu_render_host.sv
`timescale 1ns/1ns
module pbu_render_host (
  input wire logic mclk,
  input wire logic nrst,
  pbu_pixel_bus_if.host bus,
  input wire logic cmd_valid,
  input wire logic cmd_two_cycle,
  input wire logic [pbu_pkg::BUS_W-1:0] cmd_pre_data,
  input wire logic [pbu_pkg::UNITS-1:0] cmd_pre_ext,
  input wire logic [pbu_pkg::BUS_W-1:0] cmd_data,
  input wire logic [pbu_pkg::UNITS-1:0] cmd_ext,
  input wire logic [pbu_pkg::UNITS-1:0] cmd_be,
  output logic cmd_ready
);
  typedef enum logic {
    PBU_HS_IDLE, PBU_HS_SECOND
  } pbu_host_phase_t;

  typedef struct packed {
    pbu_host_phase_t phase;
    logic ready;
    logic [pbu_pkg::BUS_W-1:0] dq;
    logic [pbu_pkg::UNITS-1:0] dx;
    logic [pbu_pkg::OP_W-1:0] op;
    logic we;
    logic [pbu_pkg::UNITS-1:0] be;
    logic [pbu_pkg::BUS_W-1:0] hold_data;
    logic [pbu_pkg::UNITS-1:0] hold_ext;
  } pbu_host_state_t;

  pbu_host_state_t st_ff;
  pbu_host_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.we = 1'b0;
    unique case (st_ff.phase)
      PBU_HS_IDLE: begin
        // ready rises at the first edge after reset and drops only while a second half waits
        nxt_st.ready = 1'b1;
        if (cmd_valid && st_ff.ready) begin
          nxt_st.we = 1'b1;
          nxt_st.be = cmd_be;
          if (cmd_two_cycle) begin
            // source alpha must already sit in bits 31..24 of the data given here
            nxt_st.op = pbu_pkg::OP_INIT_TWO_CYCLE;
            nxt_st.dq = cmd_pre_data;
            nxt_st.dx = cmd_pre_ext;
            nxt_st.hold_data = cmd_data;
            nxt_st.hold_ext = cmd_ext;
            nxt_st.ready = 1'b0;
            nxt_st.phase = PBU_HS_SECOND;
          end else begin
            nxt_st.op = pbu_pkg::OP_STATEFUL_WRITE;
            nxt_st.dq = cmd_data;
            nxt_st.dx = cmd_ext;
          end
        end
      end
      PBU_HS_SECOND: begin
        // byte enables are kept from the initiate so both halves hit the same bytes
        nxt_st.we = 1'b1;
        nxt_st.op = pbu_pkg::OP_STATEFUL_WRITE;
        nxt_st.dq = st_ff.hold_data;
        nxt_st.dx = st_ff.hold_ext;
        nxt_st.ready = 1'b1;
        nxt_st.phase = PBU_HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.pixel_data_bus = st_ff.dq;
  assign bus.pixel_extension_bits = st_ff.dx;
  assign bus.pixel_op_code = st_ff.op;
  assign bus.pixel_write_enable = st_ff.we;
  assign bus.pixel_byte_enable = st_ff.be;
  assign cmd_ready = st_ff.ready;
endmodule // pbu_render_host

// File: test/pbu_sva.sv
`timescale 1ns/1ns
module pbu_sva (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [pbu_pkg::OP_W-1:0] pixel_op_code,
  input wire logic pixel_write_enable,
  input wire logic [pbu_pkg::UNITS-1:0] pixel_byte_enable,
  input wire logic pass_out,
  input wire logic [1:0] pass_in,
  input wire logic [pbu_pkg::BUS_W-1:0] pbuf_wr_data,
  input wire logic [pbu_pkg::UNITS-1:0] pbuf_wr_be,
  input wire logic preblend_armed
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic init_op;
  logic wr_op;
  assign init_op = pixel_write_enable && pixel_op_code == pbu_pkg::OP_INIT_TWO_CYCLE;
  assign wr_op = pixel_write_enable && pixel_op_code != pbu_pkg::OP_INIT_TWO_CYCLE;

  AST_INIT_FOLLOW: assert property (init_op |=> wr_op)
    else $error("initiate not followed by a write");
  AST_INIT_BE: assert property (init_op |=> $stable(pixel_byte_enable))
    else $error("byte enables changed after initiate");
  AST_ARM: assert property (init_op |=> preblend_armed)
    else $error("initiate did not arm preblend");
  AST_DISARM: assert property (wr_op |=> !preblend_armed)
    else $error("armed state kept after write");
  AST_NO_WR_INIT: assert property (init_op |=> pbuf_wr_be == 4'h0)
    else $error("initiate wrote the pixel buffer");
  AST_PASS_GATE: assert property (wr_op |=> pbuf_wr_be == ($past(pixel_byte_enable)
    & {4{$past(pass_out) && $past(pass_in) == pbu_pkg::PASS_IN_ALL}}))
    else $error("write enables not gated by pass");
  AST_BE_PULSE: assert property (!pixel_write_enable |=> pbuf_wr_be == 4'h0)
    else $error("write enable without a write");
  AST_DATA_HOLD: assert property (!wr_op |=> $stable(pbuf_wr_data))
    else $error("result changed without a write");
endmodule // pbu_sva

// File: test/pixel_blend_unit_datapath_test.sv
`timescale 1ns/1ns
module pixel_blend_unit_datapath_test;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] pbuf_rd_data, cmd_pre_data, cmd_data, pbuf_wr_data, ew, eo;
  logic [35:0] const_value;
  logic pass_out, cmd_valid, cmd_two_cycle, cmd_ready, preblend_armed;
  logic [1:0] pass_in;
  logic [3:0] cmd_pre_ext, cmd_ext, cmd_be, pbuf_wr_be, eb;
  pbu_pkg::pbu_frac_sel_t fs_c, fs_a;
  pbu_pkg::pbu_data_sel_t ds_c, ds_a, ps_c, ps_a;
  pbu_pkg::pbu_add_sel_t as_c, as_a;
  pbu_pkg::pbu_loop_sel_t ls_c, ls_a;
  int num_errors = 0;
  int cmp_count = 0;
  int t;

  always #20 mclk = ~mclk;

  pbu_pixel_bus_if bus_if ();
  pbu_blend_device i_pbu_blend_device (.mclk(mclk), .nrst(nrst), .bus(bus_if),
    .pbuf_rd_data(pbuf_rd_data), .const_value(const_value), .pass_out(pass_out),
    .pass_in(pass_in), .frac_sel_color(fs_c), .frac_sel_alpha(fs_a),
    .data_sel_color(ds_c), .data_sel_alpha(ds_a), .add_sel_color(as_c),
    .add_sel_alpha(as_a), .pre_data_sel_color(ps_c), .pre_data_sel_alpha(ps_a),
    .loop_sel_color(ls_c), .loop_sel_alpha(ls_a), .pbuf_wr_data(pbuf_wr_data),
    .pbuf_wr_be(pbuf_wr_be), .preblend_armed(preblend_armed));
  pbu_render_host i_pbu_render_host (.mclk(mclk), .nrst(nrst), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_two_cycle(cmd_two_cycle), .cmd_pre_data(cmd_pre_data),
    .cmd_pre_ext(cmd_pre_ext), .cmd_data(cmd_data), .cmd_ext(cmd_ext),
    .cmd_be(cmd_be), .cmd_ready(cmd_ready));
  pbu_sva i_pbu_sva (.mclk(mclk), .nrst(nrst), .pixel_op_code(bus_if.pixel_op_code),
    .pixel_write_enable(bus_if.pixel_write_enable),
    .pixel_byte_enable(bus_if.pixel_byte_enable), .pass_out(pass_out),
    .pass_in(pass_in), .pbuf_wr_data(pbuf_wr_data), .pbuf_wr_be(pbuf_wr_be),
    .preblend_armed(preblend_armed));

  task automatic results();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] prod(pbu_pkg::pbu_frac_sel_t fs,
    pbu_pkg::pbu_data_sel_t ds, logic [31:0] dq, logic [3:0] dx, int n);
    logic [8:0] f;
    logic [7:0] d;
    logic [7:0] ad;
    logic [16:0] p;
    ad = ~pbuf_rd_data[31:24];
    case (fs)
      pbu_pkg::PBU_FR_BUS: f = {dx[n], dq[8*n+:8]};
      pbu_pkg::PBU_FR_ALPHA_BUS: f = {dx[3], dq[31:24]};
      pbu_pkg::PBU_FR_PBUF: f = {1'b0, pbuf_rd_data[8*n+:8]};
      pbu_pkg::PBU_FR_CONST: f = const_value[9*n+:9];
      default: f = 9'h100;
    endcase
    if (f > 9'h100) f = 9'h100;
    case (ds)
      pbu_pkg::PBU_DT_PBUF: d = pbuf_rd_data[8*n+:8];
      pbu_pkg::PBU_DT_PBUF_INV: d = ~pbuf_rd_data[8*n+:8];
      pbu_pkg::PBU_DT_ASAT: d = (dq[31:24] < ad) ? dq[31:24] : ad;
      pbu_pkg::PBU_DT_SRC_ALPHA: d = dq[31:24];
      pbu_pkg::PBU_DT_DST_ALPHA: d = pbuf_rd_data[31:24];
      default: d = ad;
    endcase
    p = f * d;
    return p[15:8];
  endfunction

  // unit 3 takes the alpha selects, the rest the colour ones
  function automatic logic [31:0] expect_word();
    logic [31:0] w;
    logic [9:0] s;
    logic [7:0] lb;
    logic al;
    for (int n = 0; n < 4; n++) begin
      al = (n == 3);
      if (cmd_two_cycle) begin
        lb = prod(pbu_pkg::PBU_FR_BUS, al ? ps_a : ps_c, cmd_pre_data, cmd_pre_ext, n);
        if ((al ? ls_a : ls_c) == pbu_pkg::PBU_LB_ADD) lb = cmd_pre_data[8*n+:8];
        s = {2'h0, lb};
      end else begin
        case (al ? as_a : as_c)
          pbu_pkg::PBU_AD_BUS: s = {{2{cmd_ext[n]}}, cmd_data[8*n+:8]};
          pbu_pkg::PBU_AD_CONST: s = {const_value[9*n+8], const_value[9*n+:9]};
          default: s = {2'h0, pbuf_rd_data[8*n+:8]};
        endcase
      end
      s = s + {2'h0, prod(al ? fs_a : fs_c, al ? ds_a : ds_c, cmd_data, cmd_ext, n)};
      w[8*n+:8] = s[9] ? 8'h00 : (s > 10'h0FF ? 8'hFF : s[7:0]);
    end
    return w;
  endfunction

  // first two commands push the fraction clamp and the low saturation end
  task automatic draw(int i);
    cmd_two_cycle <= 1'($urandom_range(1));
    cmd_pre_data <= $urandom;
    cmd_pre_ext <= 4'($urandom);
    cmd_data <= i == 0 ? 32'hFFFFFFFF : (i == 1 ? 32'h0 : $urandom);
    cmd_ext <= i < 2 ? 4'hF : 4'($urandom);
    cmd_be <= 4'($urandom);
    pbuf_rd_data <= $urandom;
    const_value <= {4'($urandom), $urandom};
    pass_out <= $urandom_range(3) != 0;
    pass_in <= $urandom_range(3) != 0 ? 2'h3 : 2'($urandom);
    fs_c <= pbu_pkg::pbu_frac_sel_t'($urandom_range(4));
    fs_a <= pbu_pkg::pbu_frac_sel_t'($urandom_range(4));
    ds_c <= pbu_pkg::pbu_data_sel_t'($urandom_range(5));
    ds_a <= pbu_pkg::pbu_data_sel_t'($urandom_range(5));
    ps_c <= pbu_pkg::pbu_data_sel_t'($urandom_range(5));
    ps_a <= pbu_pkg::pbu_data_sel_t'($urandom_range(5));
    as_c <= pbu_pkg::pbu_add_sel_t'($urandom_range(2));
    as_a <= pbu_pkg::pbu_add_sel_t'($urandom_range(2));
    ls_c <= pbu_pkg::pbu_loop_sel_t'($urandom_range(1));
    ls_a <= pbu_pkg::pbu_loop_sel_t'($urandom_range(1));
  endtask

  initial begin
    void'($urandom(32'hDCE8));
    cmd_valid <= 1'b0;
    draw(2);
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #1;
    chk("reset wr_be", {28'h0, pbuf_wr_be}, 32'h0);
    for (int i = 0; i < 300; i++) begin
      @(posedge mclk);
      draw(i);
      cmd_valid <= 1'b1;
      #1;
      t = 0;
      while (cmd_ready !== 1'b1 && t < 20) begin
        @(posedge mclk);
        #1;
        t++;
      end
      if (t == 20) begin
        num_errors++;
        results();
      end
      ew = expect_word();
      eb = cmd_be & {4{pass_out && pass_in == 2'h3}};
      @(posedge mclk);
      cmd_valid <= 1'b0;
      #1;
      eo = {28'h0, 1'b1,
        cmd_two_cycle ? pbu_pkg::OP_INIT_TWO_CYCLE : pbu_pkg::OP_STATEFUL_WRITE};
      chk("bus op", {28'h0, bus_if.pixel_write_enable, bus_if.pixel_op_code}, eo);
      chk("bus dq", bus_if.pixel_data_bus, cmd_two_cycle ? cmd_pre_data : cmd_data);
      chk("bus be", {28'h0, bus_if.pixel_byte_enable}, {28'h0, cmd_be});
      chk("ready", {31'h0, cmd_ready}, {31'h0, !cmd_two_cycle});
      t = 0;
      while (!(bus_if.pixel_write_enable === 1'b1 &&
          bus_if.pixel_op_code !== pbu_pkg::OP_INIT_TWO_CYCLE) && t < 20) begin
        @(posedge mclk);
        #1;
        t++;
      end
      if (t == 20) begin
        num_errors++;
        results();
      end
      chk("armed", {31'h0, preblend_armed}, {31'h0, cmd_two_cycle});
      @(posedge mclk);
      #1;
      chk("wr_be", {28'h0, pbuf_wr_be}, {28'h0, eb});
      chk("wr_data", pbuf_wr_data, ew);
      chk("disarmed", {31'h0, preblend_armed}, 32'h0);
    end
    results();
  end
endmodule // pixel_blend_unit_datapath_test
